// File: lvps_pkg.sv
/*
 Shared constants and carrier types for the pixel link serializer.
 Assumes a 125 MHz system clock and an SystemVerilog-2012 tool flow.
*/
package lvps_pkg;
   localparam int unsigned SYS_CLK_KHZ = 125_000;
   localparam int unsigned LOCK_TIME_MS = 10;
   localparam int unsigned LOCK_CYCLES = LOCK_TIME_MS * SYS_CLK_KHZ;
   localparam int unsigned SLOTS = 7;
   localparam int unsigned LANES_WIDE = 4;
   localparam int unsigned LANES_NARROW = 3;
   localparam int unsigned COLOUR_WIDE = 24;
   localparam int unsigned COLOUR_NARROW = 18;
   localparam int unsigned FIFO_DEPTH_DEF = 8;
   localparam int unsigned BIT_CYCLES_DEF = 1;
   localparam int unsigned CLK_LOSS_CYCLES = 64;
   localparam logic [6:0] CLK_LANE_PATTERN = 7'h63;
   localparam logic [6:0] LAST_SLOT = 7'h06;

   typedef struct packed {
      logic pixel_data_valid;
      logic frame_sync;
      logic line_sync;
   } lvps_ctrl_t;

   typedef enum logic {
      LVPS_IDLE,
      LVPS_SHIFT
   } lvps_state_t;
endpackage

// File: lvps_serializer.sv
/*
 Pixel link serializer: pin synchronisers, edge capture, word FIFO,
 lock timer and the seven-slot lane shifter with its clock lane.
 Assumes every pin input is asynchronous to i_clk and that the pad ring
 resolves the differential drivers from the output enable.
*/
`timescale 1ns/10ps

module lvps_fifo #(
   parameter int W = 28,
   parameter int DEPTH = 8
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_flush,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [W-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [W-1:0] o_out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
         $error("FIFO depth must be a power of two of at least 2");
      end
   endgenerate

   logic [W-1:0] mem_r [DEPTH];
   logic [AW:0] wr_ptr_r;
   logic [AW:0] rd_ptr_r;
   wire full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
   wire empty = (wr_ptr_r == rd_ptr_r);
   wire push = i_in_valid && !full;
   wire pop = i_out_ready && !empty;

   assign o_in_ready = !full;
   assign o_out_valid = !empty;
   assign o_out_data = mem_r[rd_ptr_r[AW-1:0]];

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_r[wr_ptr_r[AW-1:0]] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else if (i_flush) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
      end
   end
endmodule

module lvps_serializer
   import lvps_pkg::*;
#(
   parameter int LANES = LANES_WIDE,
   parameter int COLOUR_W = COLOUR_WIDE,
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
   parameter int BIT_CYCLES = BIT_CYCLES_DEF,
   parameter int LOCK_CNT = LOCK_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_parallel_input_clock,
   input wire logic i_edge_sel_rise,
   input wire logic i_pwr_down_n,
   input wire logic [COLOUR_W-1:0] i_colour,
   input wire lvps_ctrl_t i_ctrl,
   input wire logic i_spare,
   output logic [LANES-1:0] o_lane_p,
   output logic [LANES-1:0] o_lane_n,
   output logic o_clk_lane_p,
   output logic o_clk_lane_n,
   output logic o_lane_oe,
   output logic o_locked,
   output logic o_overrun
);
   localparam int W = LANES * SLOTS;
   localparam int AW = COLOUR_W + 7;
   localparam int LCW = $clog2(LOCK_CNT + 1);
   localparam int GW = $clog2(CLK_LOSS_CYCLES + 1);
   localparam int TW = $clog2(BIT_CYCLES + 1);

   generate
      if (!((LANES == LANES_WIDE && COLOUR_W == COLOUR_WIDE) ||
            (LANES == LANES_NARROW && COLOUR_W == COLOUR_NARROW))) begin : g_bad_lanes
         $error("Only 4 lanes with 24 colour bits or 3 lanes with 18");
      end
      if (BIT_CYCLES < 1 || LOCK_CNT < 1) begin : g_bad_count
         $error("Bit and lock counts must be at least 1");
      end
   endgenerate

   function automatic logic [LANES-1:0] lane_bits(input logic [W-1:0] word,
                                                 input logic [2:0] slot);
      logic [LANES-1:0] b;
      b = '0;
      for (int l = 0; l < LANES; l++) begin
         b[l] = word[l * SLOTS + int'(slot)];
      end
      return b;
   endfunction

   // Reset release
   logic rst_meta_r;
   logic rst_n_r;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   // Pin synchronisers plus one delay stage
   wire [AW-1:0] async_in = {i_parallel_input_clock, i_edge_sel_rise, i_pwr_down_n,
                             i_spare, i_ctrl, i_colour};
   logic [AW-1:0] sync1_r;
   logic [AW-1:0] sync2_r;
   logic [AW-1:0] sync3_r;
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         sync1_r <= '0;
         sync2_r <= '0;
         sync3_r <= '0;
      end else begin
         sync1_r <= async_in;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   wire clk_now = sync2_r[AW-1];
   wire clk_prev = sync3_r[AW-1];
   wire sel_rise = sync2_r[AW-2];
   wire pwr_on = sync2_r[AW-3];
   wire rise = clk_now && !clk_prev;
   wire fall = !clk_now && clk_prev;
   wire cap_edge = sel_rise ? rise : fall;
   wire [COLOUR_W+3:0] full_word = sync3_r[COLOUR_W+3:0];
   wire [W-1:0] word_in = full_word[W-1:0];

   // Clock presence and lock timer
   logic [GW-1:0] gap_r;
   logic [LCW-1:0] lock_cnt_r;
   wire alive = gap_r < GW'(CLK_LOSS_CYCLES);
   wire locked = lock_cnt_r == LCW'(LOCK_CNT);
   wire run = locked && pwr_on && alive;
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         gap_r <= GW'(CLK_LOSS_CYCLES);
         lock_cnt_r <= '0;
      end else begin
         gap_r <= (rise || fall) ? '0 : (alive ? gap_r + 1'b1 : gap_r);
         if (!pwr_on || !alive) begin
            lock_cnt_r <= '0;
         end else if (!locked) begin
            lock_cnt_r <= lock_cnt_r + 1'b1;
         end
      end
   end

   // Word FIFO
   wire push = cap_edge && run;
   wire in_ready;
   wire out_valid;
   wire [W-1:0] out_data;
   lvps_state_t st_r;
   logic [2:0] slot_r;
   logic [TW-1:0] tick_r;
   logic [W-1:0] word_r;
   wire bit_done = tick_r == TW'(BIT_CYCLES - 1);
   wire last = (st_r == LVPS_SHIFT) && bit_done && (slot_r == LAST_SLOT[2:0]);
   wire pop = run && out_valid && ((st_r == LVPS_IDLE) || last);

   lvps_fifo #(.W(W), .DEPTH(FIFO_DEPTH)) lvps_fifo_inst (
      .i_clk(i_clk),
      .i_rst_n(rst_n_r),
      .i_flush(!run),
      .i_in_valid(push),
      .o_in_ready(in_ready),
      .i_in_data(word_in),
      .o_out_valid(out_valid),
      .i_out_ready(pop),
      .o_out_data(out_data)
   );

   // Shifter next values
   wire adv = (st_r == LVPS_SHIFT) && bit_done && !last;
   wire [W-1:0] word_nxt = pop ? out_data : word_r;
   wire [2:0] slot_nxt = pop ? 3'h0 : (adv ? slot_r + 3'h1 : slot_r);
   wire shift_nxt = run && (pop || ((st_r == LVPS_SHIFT) && !last));
   wire [LANES-1:0] lane_nxt = shift_nxt ? lane_bits(word_nxt, slot_nxt) : '0;
   wire clkl_nxt = shift_nxt && CLK_LANE_PATTERN[3'h6 - slot_nxt];

   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         st_r <= LVPS_IDLE;
         slot_r <= '0;
         tick_r <= '0;
         word_r <= '0;
      end else begin
         word_r <= word_nxt;
         slot_r <= slot_nxt;
         tick_r <= (pop || bit_done || !shift_nxt) ? '0 : tick_r + 1'b1;
         case (st_r)
            LVPS_IDLE: st_r <= (run && pop) ? LVPS_SHIFT : LVPS_IDLE;
            LVPS_SHIFT: st_r <= shift_nxt ? LVPS_SHIFT : LVPS_IDLE;
            default: st_r <= LVPS_IDLE;
         endcase
      end
   end

   // Output flops
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_lane_p <= '0;
         o_lane_n <= '0;
         o_clk_lane_p <= 1'b0;
         o_clk_lane_n <= 1'b0;
         o_lane_oe <= 1'b0;
         o_locked <= 1'b0;
         o_overrun <= 1'b0;
      end else begin
         o_lane_p <= pwr_on ? lane_nxt : '0;
         o_lane_n <= pwr_on ? ~lane_nxt : '0;
         o_clk_lane_p <= pwr_on && clkl_nxt;
         o_clk_lane_n <= pwr_on && !clkl_nxt;
         o_lane_oe <= pwr_on;
         o_locked <= run;
         o_overrun <= push && !in_ready;
      end
   end
endmodule

// File: lvps_checker.sv
/*
 Port checker for the pixel link serializer.
 Assumes bind onto lvps_serializer; watches its ports only.
*/
`timescale 1ns/10ps
module lvps_checker
   import lvps_pkg::*;
#(
   parameter int LANES = 4,
   parameter int LOCK_CNT = 50
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_pwr_down_n,
   input wire logic [LANES-1:0] o_lane_p,
   input wire logic [LANES-1:0] o_lane_n,
   input wire logic o_clk_lane_p,
   input wire logic o_clk_lane_n,
   input wire logic o_lane_oe,
   input wire logic o_locked,
   input wire logic o_overrun
);
   logic [2:0] slot_r;
   logic [31:0] up_r;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         slot_r <= 3'h0;
         up_r <= 32'h0000_0000;
      end else begin
         up_r <= o_lane_oe ? up_r + 32'h0000_0001 : 32'h0000_0000;
         if (!o_lane_oe)
            slot_r <= 3'h0;
         else if (slot_r != 3'h0 || o_clk_lane_p)
            slot_r <= (slot_r == 3'h6) ? 3'h0 : slot_r + 3'h1;
      end
   end
   a_lane_compl:
      assert property (o_lane_oe |-> o_lane_n == ~o_lane_p) else $error("lane pair skew");
   a_clk_diff:
      assert property (o_lane_oe |-> o_clk_lane_n == !o_clk_lane_p) else $error("clk pair skew");
   a_clk_slots:
      assert property (o_lane_oe && slot_r != 3'h0 |-> o_clk_lane_p == CLK_LANE_PATTERN[3'h6 - slot_r])
      else $error("clock lane slot wrong");
   a_pd_quiet:
      assert property (!o_lane_oe |-> o_lane_p == '0 && o_lane_n == '0 && !o_clk_lane_p
         && !o_clk_lane_n) else $error("driver active while off");
   a_pd_oe_off:
      assert property (!i_pwr_down_n [*4] |=> !o_lane_oe) else $error("oe still high");
   a_pu_oe_on:
      assert property (i_pwr_down_n [*8] |=> o_lane_oe) else $error("oe not high");
   a_pd_unlock:
      assert property (!i_pwr_down_n [*5] |=> !o_locked) else $error("locked while down");
   a_lock_wait:
      assert property ($rose(o_locked) |-> up_r >= LOCK_CNT - 1) else $error("lock too early");
   a_ovr_pulse:
      assert property (o_overrun |=> !o_overrun) else $error("overrun too long");
   cover property ($rose(o_locked));
   cover property (o_overrun);
   cover property (slot_r == 3'h6);
endmodule
bind lvps_serializer lvps_checker #(.LANES(LANES), .LOCK_CNT(LOCK_CNT)) lvps_checker_inst (
   .i_clk, .i_rst_n, .i_pwr_down_n, .o_lane_p, .o_lane_n, .o_clk_lane_p, .o_clk_lane_n,
   .o_lane_oe, .o_locked, .o_overrun);

// File: lvps_rx_model.sv
/*
 Panel receiver model: frames on the clock lane, rebuilds words.
 Assumes one i_clk cycle per slot and four lanes.
*/
`timescale 1ns/10ps
module lvps_rx_model (
   input wire logic i_clk,
   input wire logic i_oe,
   input wire logic [3:0] i_lane,
   input wire logic i_clk_lane,
   output logic o_valid,
   output logic [27:0] o_word
);
   logic [2:0] s_r;
   always @(posedge i_clk) begin
      o_valid <= 1'b0;
      if (!i_oe)
         s_r <= 3'h0;
      else if (s_r != 3'h0 || i_clk_lane) begin
         for (int l = 0; l < 4; l++)
            o_word[l*7+s_r] <= i_lane[l];
         s_r <= (s_r == 3'h6) ? 3'h0 : s_r + 3'h1;
         o_valid <= (s_r == 3'h6);
      end
   end
endmodule

// File: tb_lvds_pixel_serializer.sv
/*
 Testbench for the pixel link serializer.
 Assumes the receiver model and checker files compile first.
*/
`timescale 1ns/10ps
module tb_lvds_pixel_serializer;
   import lvps_pkg::*;
   logic i_clk = 0, i_rst_n = 0, lc = 0, sel = 1, pwr = 1, run = 1, en = 0, spare = 0;
   logic [23:0] col = '0;
   lvps_ctrl_t ctl = '0;
   logic [3:0] lp, ln;
   logic ckp, ckn, oe, lkd, ovr, rv;
   logic [27:0] rw;
   logic [27:0] q[$];
   time qt[$];
   logic [31:0] rs = 32'h0001_10a9;
   int n_fail = 0, tests_run = 0, half = 5, cnt = 0, novr = 0;
   lvps_serializer #(.LOCK_CNT(50)) lvps_serializer_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_parallel_input_clock(lc), .i_edge_sel_rise(sel), .i_pwr_down_n(pwr), .i_colour(col),
      .i_ctrl(ctl), .i_spare(spare), .o_lane_p(lp), .o_lane_n(ln), .o_clk_lane_p(ckp),
      .o_clk_lane_n(ckn), .o_lane_oe(oe), .o_locked(lkd), .o_overrun(ovr));
   lvps_rx_model lvps_rx_model_inst (.i_clk(i_clk), .i_oe(oe), .i_lane(lp), .i_clk_lane(ckp),
      .o_valid(rv), .o_word(rw));
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      return v ^ (v << 5);
   endfunction
   task automatic chk(input logic [27:0] s, input logic [27:0] e);
      tests_run++;
      if (s !== e) begin
         n_fail++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic give_verdict();
      if (n_fail == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wait_lock();
      for (int k = 0; k < 2000 && lkd !== 1'b1; k++)
         @(negedge i_clk);
      chk({27'h000_0000, lkd}, 28'h000_0001);
   endtask
   always #4 i_clk = ~i_clk;
   always @(negedge i_clk) begin
      cnt <= (run && cnt < half - 1) ? cnt + 1 : 0;
      if (run && cnt == half - 1) begin
         lc <= ~lc;
         if ((~lc) == sel) begin
            if (en) begin
               q.push_back({spare, ctl, col});
               qt.push_back($time);
            end
         end else begin
            rs = xs(rs);
            {spare, ctl, col} <= en ? rs[27:0] : 28'h000_0000;
         end
      end
   end
   // Notes younger than one word's latency belong to later words
   always @(negedge i_clk) begin
      if (rv === 1'b1) begin
         if (q.size() != 0 && $time - qt[0] >= 64) begin
            void'(qt.pop_front());
            chk(rw, q.pop_front());
         end else if (rw !== 28'h000_0000) begin
            chk(rw, 28'h000_0000);
         end
      end
      if (ovr === 1'b1) begin
         novr++;
         if (q.size() != 0) begin
            void'(q.pop_back());
            void'(qt.pop_back());
         end
      end
   end
   initial begin
      #30000;
      n_fail++;
      give_verdict();
   end
   initial begin
      repeat (2) @(negedge i_clk);
      i_rst_n = 1;
      wait_lock();
      repeat (20) @(negedge i_clk);
      en = 1;
      repeat (80) @(negedge i_clk);
      @(negedge i_clk iff cnt == 0);
      sel = 0;
      repeat (80) @(negedge i_clk);
      half = 3;
      repeat (600) @(negedge i_clk);
      chk({27'h000_0000, novr != 0}, 28'h000_0001);
      half = 5;
      repeat (200) @(negedge i_clk);
      run = 0;
      repeat (150) @(negedge i_clk);
      chk(28'(q.size()), 28'h000_0000);
      en = 0;
      {spare, ctl, col} = 28'h000_0000;
      pwr = 0;
      repeat (10) @(negedge i_clk);
      chk({16'h0000, oe, lkd, lp, ln, ckp, ckn}, 28'h000_0000);
      pwr = 1;
      run = 1;
      repeat (20) @(negedge i_clk);
      chk({27'h000_0000, lkd}, 28'h000_0000);
      wait_lock();
      en = 1;
      repeat (100) @(negedge i_clk);
      give_verdict();
   end
endmodule
